// ===== rtl/cpsq_core.v
// cpsq_core: instruction sequencer, program counter, return stack and alu
`include "cpsq_defines.vh"

module cpsq_core #(
	parameter STACK_DEPTH = 8,
	parameter SP_W = 4
) (
	input wire core_clk,
	input wire rst_b,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire [31:0] prdata,
	output wire pslverr,
	output wire [10:0] prog_addr,
	input wire [15:0] prog_data,
	input wire int_req,
	output wire int_ack,
	output wire [3:0] instruction_phase_clocks
);

localparam PH_T1 = 4'b0001;
localparam PH_T2 = 4'b0010;
localparam PH_T3 = 4'b0100;
localparam PH_T4 = 4'b1000;
localparam [SP_W-1:0] SP_FULL = STACK_DEPTH[SP_W-1:0];
localparam [SP_W-1:0] SP_ONE = {{(SP_W-1){1'b0}}, 1'b1};

////////////////////////////////////////////////////////////////////////////////
// functions

function [10:0] add_f;
	input [7:0] a;
	input [7:0] b;
	input ci;
	reg [4:0] lo;
	reg [8:0] sum;
	begin
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
		sum = {1'b0, a} + {1'b0, b} + {8'h00, ci};
		add_f = {(a[7] == b[7]) && (sum[7] != a[7]), lo[4], sum[8], sum[7:0]};
	end
endfunction

function reg_hit;
	input [11:0] a;
	begin
		reg_hit = (a == `CPSQ_REG_PCLOW) || (a == `CPSQ_REG_ACC) ||
			(a == `CPSQ_REG_MEM) || (a == `CPSQ_REG_STAT) ||
			(a == `CPSQ_REG_CTRL);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// state

reg [3:0] phase_reg;
reg [3:0] phase_next;
reg [10:0] pc_reg;
reg [10:0] prog_addr_reg;
reg [15:0] fetch_reg;
reg fetch_valid_reg;
reg [15:0] ir_reg;
reg ir_valid_reg;
reg [7:0] acc_reg;
reg [7:0] mem_reg;
reg c_reg;
reg ac_reg;
reg z_reg;
reg ov_reg;
reg run_reg;
reg int_en_reg;
reg int_pend_reg;
reg int_ack_reg;
reg lowb_pend_reg;
reg [7:0] lowb_val_reg;
reg [SP_W-1:0] sp_reg;
reg [10:0] stk_mem [0:STACK_DEPTH-1];
reg pready_reg;
reg [31:0] prdata_reg;
reg pslverr_reg;

assign pready = pready_reg;
assign prdata = prdata_reg;
assign pslverr = pslverr_reg;
assign prog_addr = prog_addr_reg;
assign int_ack = int_ack_reg;
assign instruction_phase_clocks = phase_reg;

////////////////////////////////////////////////////////////////////////////////
// phase generator

always @* begin
	case (phase_reg)
		PH_T1: phase_next = PH_T2;
		PH_T2: phase_next = PH_T3;
		PH_T3: phase_next = PH_T4;
		PH_T4: phase_next = PH_T1;
		default: phase_next = PH_T1;
	endcase
end

wire exec = run_reg & (phase_reg == PH_T4);
wire fetch_cap = run_reg & (phase_reg == PH_T2);

////////////////////////////////////////////////////////////////////////////////
// decode and alu

wire [4:0] op = ir_reg[`CPSQ_OP_HI:`CPSQ_OP_LO];
wire to_mem = ir_reg[`CPSQ_DEST_BIT];
wire [10:0] tgt = ir_reg[`CPSQ_TGT_HI:0];
wire [7:0] imm = ir_reg[`CPSQ_IMM_HI:0];
wire is_jmp = ir_valid_reg & (op == `CPSQ_OP_JUMP);
wire is_call = ir_valid_reg & (op == `CPSQ_OP_CALL);
wire is_ret = ir_valid_reg & ((op == `CPSQ_OP_SRET) | (op == `CPSQ_OP_IRET));
wire stack_full = (sp_reg == SP_FULL);

reg [7:0] res;
reg c_n;
reg ac_n;
reg z_n;
reg ov_n;
reg res_wr;
reg skip;
reg [8:0] dtmp;

always @* begin
	res = acc_reg;
	c_n = c_reg;
	ac_n = ac_reg;
	z_n = z_reg;
	ov_n = ov_reg;
	res_wr = 1'b0;
	skip = 1'b0;
	dtmp = {1'b0, acc_reg};
	case (op)
		`CPSQ_OP_ADD: begin
			{ov_n, ac_n, c_n, res} = add_f(acc_reg, mem_reg, 1'b0);
			res_wr = 1'b1;
		end
		`CPSQ_OP_ADC: begin
			{ov_n, ac_n, c_n, res} = add_f(acc_reg, mem_reg, c_reg);
			res_wr = 1'b1;
		end
		`CPSQ_OP_SUB: begin
			{ov_n, ac_n, c_n, res} = add_f(acc_reg, ~mem_reg, 1'b1);
			res_wr = 1'b1;
		end
		`CPSQ_OP_SBC: begin
			{ov_n, ac_n, c_n, res} = add_f(acc_reg, ~mem_reg, c_reg);
			res_wr = 1'b1;
		end
		`CPSQ_OP_DADJ: begin
			if ((acc_reg[3:0] > `CPSQ_DADJ_LIM) || ac_reg) begin
				dtmp = dtmp + `CPSQ_DADJ_LO;
			end
			if ((dtmp[7:4] > `CPSQ_DADJ_LIM) || dtmp[8] || c_reg) begin
				dtmp = dtmp + `CPSQ_DADJ_HI;
			end
			res = dtmp[7:0];
			c_n = dtmp[8] | c_reg;
			res_wr = 1'b1;
		end
		`CPSQ_OP_AND: begin
			res = acc_reg & mem_reg;
			res_wr = 1'b1;
		end
		`CPSQ_OP_OR: begin
			res = acc_reg | mem_reg;
			res_wr = 1'b1;
		end
		`CPSQ_OP_XOR: begin
			res = acc_reg ^ mem_reg;
			res_wr = 1'b1;
		end
		`CPSQ_OP_CPL: begin
			res = ~mem_reg;
			res_wr = 1'b1;
		end
		`CPSQ_OP_RR: begin
			res = {mem_reg[0], mem_reg[7:1]};
			res_wr = 1'b1;
		end
		`CPSQ_OP_RRCY: begin
			res = {c_reg, mem_reg[7:1]};
			c_n = mem_reg[0];
			res_wr = 1'b1;
		end
		`CPSQ_OP_RL: begin
			res = {mem_reg[6:0], mem_reg[7]};
			res_wr = 1'b1;
		end
		`CPSQ_OP_RLCY: begin
			res = {mem_reg[6:0], c_reg};
			c_n = mem_reg[7];
			res_wr = 1'b1;
		end
		`CPSQ_OP_INC: begin
			res = mem_reg + 8'h01;
			res_wr = 1'b1;
		end
		`CPSQ_OP_DEC: begin
			res = mem_reg - 8'h01;
			res_wr = 1'b1;
		end
		`CPSQ_OP_SZ: begin
			skip = (mem_reg == 8'h00);
		end
		`CPSQ_OP_SNZ: begin
			skip = (mem_reg != 8'h00);
		end
		`CPSQ_OP_SIZ: begin
			res = mem_reg + 8'h01;
			res_wr = 1'b1;
			skip = (res == 8'h00);
		end
		`CPSQ_OP_SDZ: begin
			res = mem_reg - 8'h01;
			res_wr = 1'b1;
			skip = (res == 8'h00);
		end
		`CPSQ_OP_MOVI: begin
			res = imm;
			res_wr = 1'b1;
		end
		default: begin
			res_wr = 1'b0;
		end
	endcase
	// zero flag from logic and arithmetic results
	if (res_wr && (op <= `CPSQ_OP_CPL || op == `CPSQ_OP_INC || op == `CPSQ_OP_DEC)) begin
		z_n = (res == 8'h00);
	end
end

////////////////////////////////////////////////////////////////////////////////
// flow control

wire branch = is_jmp | is_call | is_ret | (ir_valid_reg & skip);
// page-local jump from low byte write
wire lowb_apply = lowb_pend_reg & ~branch;
wire flush = branch | lowb_apply;
// interrupt withheld while stack is full
wire int_take = exec & int_pend_reg & int_en_reg & ~stack_full & ~flush;
wire push = exec & (is_call | int_take);
wire pop = exec & is_ret;

reg [10:0] pc_tgt;

always @* begin
	if (is_jmp | is_call) begin
		pc_tgt = tgt;
	end else if (is_ret) begin
		pc_tgt = stk_mem[0];
	end else if (lowb_apply) begin
		pc_tgt = {pc_reg[10:8], lowb_val_reg};
	end else if (int_take) begin
		pc_tgt = `CPSQ_INT_VECTOR;
	end else begin
		pc_tgt = pc_reg;
	end
end

////////////////////////////////////////////////////////////////////////////////
// sequencer registers

always @(posedge core_clk) begin
	if (!rst_b) begin
		phase_reg <= PH_T1;
		pc_reg <= `CPSQ_RESET_VECTOR + 11'h001;
		prog_addr_reg <= `CPSQ_RESET_VECTOR;
		fetch_reg <= 16'h0000;
		fetch_valid_reg <= 1'b0;
		ir_reg <= 16'h0000;
		ir_valid_reg <= 1'b0;
		acc_reg <= 8'h00;
		c_reg <= 1'b0;
		ac_reg <= 1'b0;
		z_reg <= 1'b0;
		ov_reg <= 1'b0;
		int_pend_reg <= 1'b0;
		int_ack_reg <= 1'b0;
	end else begin
		if (run_reg) begin
			phase_reg <= phase_next;
		end
		// capture fetched word in the second phase, after the first phase's read
		if (fetch_cap) begin
			fetch_reg <= prog_data;
			fetch_valid_reg <= 1'b1;
		end
		// prefetched word becomes the next instruction
		if (exec) begin
			ir_reg <= fetch_reg;
			ir_valid_reg <= fetch_valid_reg & ~flush & ~int_take;
			// issue fetch and advance pc entering first phase
			prog_addr_reg <= pc_tgt;
			pc_reg <= pc_tgt + 11'h001;
			if (ir_valid_reg && res_wr && !to_mem) begin
				acc_reg <= res;
			end
			if (ir_valid_reg) begin
				c_reg <= c_n;
				ac_reg <= ac_n;
				z_reg <= z_n;
				ov_reg <= ov_n;
			end
		end
		// request recorded; a new request wins over the acknowledge
		int_pend_reg <= int_req | (int_pend_reg & ~int_take);
		int_ack_reg <= int_take;
	end
end

////////////////////////////////////////////////////////////////////////////////
// return stack

integer i;

always @(posedge core_clk) begin
	if (!rst_b) begin
		sp_reg <= {SP_W{1'b0}};
	end else if (push) begin
		// push return address of the discarded prefetch
		// shifting drops the oldest entry on overflow
		for (i = STACK_DEPTH - 1; i > 0; i = i - 1) begin
			stk_mem[i] <= stk_mem[i-1];
		end
		stk_mem[0] <= prog_addr_reg;
		if (!stack_full) begin
			sp_reg <= sp_reg + SP_ONE;
		end
	end else if (pop) begin
		for (i = 0; i < STACK_DEPTH - 1; i = i + 1) begin
			stk_mem[i] <= stk_mem[i+1];
		end
		if (sp_reg != {SP_W{1'b0}}) begin
			sp_reg <= sp_reg - SP_ONE;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// apb slave

wire apb_acc = psel & penable;
wire apb_wr = apb_acc & pwrite & pready_reg;
reg [31:0] rd_mux;

// only the pc low byte is visible
// no stack view in the map
always @* begin
	rd_mux = 32'h0000_0000;
	case (paddr)
		`CPSQ_REG_PCLOW: rd_mux[7:0] = pc_reg[7:0];
		`CPSQ_REG_ACC: rd_mux[7:0] = acc_reg;
		`CPSQ_REG_MEM: rd_mux[7:0] = mem_reg;
		`CPSQ_REG_STAT: begin
			rd_mux[`CPSQ_ST_C] = c_reg;
			rd_mux[`CPSQ_ST_AC] = ac_reg;
			rd_mux[`CPSQ_ST_Z] = z_reg;
			rd_mux[`CPSQ_ST_OV] = ov_reg;
		end
		`CPSQ_REG_CTRL: begin
			rd_mux[`CPSQ_CTRL_RUN] = run_reg;
			rd_mux[`CPSQ_CTRL_INTEN] = int_en_reg;
		end
		default: rd_mux = 32'h0000_0000;
	endcase
end

always @(posedge core_clk) begin
	if (!rst_b) begin
		pready_reg <= 1'b0;
		prdata_reg <= 32'h0000_0000;
		pslverr_reg <= 1'b0;
		run_reg <= 1'b0;
		int_en_reg <= 1'b0;
		mem_reg <= 8'h00;
		lowb_pend_reg <= 1'b0;
		lowb_val_reg <= 8'h00;
	end else begin
		pready_reg <= apb_acc & ~pready_reg;
		if (apb_acc && !pready_reg) begin
			prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
		end
		pslverr_reg <= apb_acc & ~pready_reg & ~reg_hit(paddr);
		if (apb_wr && paddr == `CPSQ_REG_CTRL) begin
			run_reg <= pwdata[`CPSQ_CTRL_RUN];
			int_en_reg <= pwdata[`CPSQ_CTRL_INTEN];
		end
		// memory destination beats a software write
		if (exec && ir_valid_reg && res_wr && to_mem) begin
			mem_reg <= res;
		end else if (apb_wr && paddr == `CPSQ_REG_MEM) begin
			mem_reg <= pwdata[7:0];
		end
		// low byte write held until an execute edge with no branch
		if (apb_wr && paddr == `CPSQ_REG_PCLOW) begin
			lowb_pend_reg <= 1'b1;
			lowb_val_reg <= pwdata[7:0];
		end else if (exec && lowb_apply) begin
			lowb_pend_reg <= 1'b0;
		end
	end
end

endmodule

// ===== rtl/cpsq_defines.vh
// cpsq constants: register map, fields, vectors and opcodes
`ifndef CPSQ_DEFINES_VH
`define CPSQ_DEFINES_VH

// register byte offsets
`define CPSQ_REG_PCLOW 12'h000
`define CPSQ_REG_ACC 12'h004
`define CPSQ_REG_MEM 12'h008
`define CPSQ_REG_STAT 12'h00C
`define CPSQ_REG_CTRL 12'h010

// control bits
`define CPSQ_CTRL_RUN 0
`define CPSQ_CTRL_INTEN 1

// status bits
`define CPSQ_ST_C 0
`define CPSQ_ST_AC 1
`define CPSQ_ST_Z 2
`define CPSQ_ST_OV 3

// vectors
`define CPSQ_RESET_VECTOR 11'h000
`define CPSQ_INT_VECTOR 11'h004

// instruction word fields
`define CPSQ_OP_HI 15
`define CPSQ_OP_LO 11
`define CPSQ_DEST_BIT 8
`define CPSQ_TGT_HI 10
`define CPSQ_IMM_HI 7

// decimal adjust constants
`define CPSQ_DADJ_LIM 4'h9
`define CPSQ_DADJ_LO 9'h006
`define CPSQ_DADJ_HI 9'h060

// opcodes
`define CPSQ_OP_NOP 5'h00
`define CPSQ_OP_ADD 5'h01
`define CPSQ_OP_ADC 5'h02
`define CPSQ_OP_SUB 5'h03
`define CPSQ_OP_SBC 5'h04
`define CPSQ_OP_DADJ 5'h05
`define CPSQ_OP_AND 5'h06
`define CPSQ_OP_OR 5'h07
`define CPSQ_OP_XOR 5'h08
`define CPSQ_OP_CPL 5'h09
`define CPSQ_OP_RR 5'h0A
`define CPSQ_OP_RRCY 5'h0B
`define CPSQ_OP_RL 5'h0C
`define CPSQ_OP_RLCY 5'h0D
`define CPSQ_OP_INC 5'h0E
`define CPSQ_OP_DEC 5'h0F
`define CPSQ_OP_SZ 5'h10
`define CPSQ_OP_SNZ 5'h11
`define CPSQ_OP_SIZ 5'h12
`define CPSQ_OP_SDZ 5'h13
`define CPSQ_OP_JUMP 5'h14
`define CPSQ_OP_CALL 5'h15
`define CPSQ_OP_SRET 5'h16
`define CPSQ_OP_IRET 5'h17
`define CPSQ_OP_MOVI 5'h18

`endif

// ===== test/cpsq_core_chk.sv
// cpsq_core_chk: port-level assertions for the sequencer core
`include "cpsq_defines.vh"

module cpsq_core_chk #(
	parameter STACK_DEPTH = 8,
	parameter SP_W = 4
) (
	input wire core_clk,
	input wire rst_b,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire [10:0] prog_addr,
	input wire [15:0] prog_data,
	input wire int_req,
	input wire int_ack,
	input wire [3:0] instruction_phase_clocks
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	////////////////////////////////////////////////////////////////
	a_phase_onehot: assert property ($onehot(instruction_phase_clocks))
		else $error("phase not one-hot");
	a_phase_rotate: assert property (instruction_phase_clocks != 4'h1 |=>
		instruction_phase_clocks == {$past(instruction_phase_clocks[2:0]),
		$past(instruction_phase_clocks[3])})
		else $error("phase sequence broken");
	a_fetch_at_t1: assert property ($changed(prog_addr) |-> instruction_phase_clocks == 4'h1)
		else $error("fetch address moved outside first phase");
	a_fetch_after_t4: assert property ($changed(prog_addr) |-> $past(instruction_phase_clocks) == 4'h8)
		else $error("fetch address moved not after last phase");
	a_ack_vector: assert property (int_ack |-> prog_addr == `CPSQ_INT_VECTOR)
		else $error("acknowledge without vector fetch");
	a_ack_pulse: assert property (int_ack |=> !int_ack)
		else $error("acknowledge longer than one cycle");
	a_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("ready not one cycle after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_ready_cause: assert property ($rose(pready) |-> $past(psel && penable))
		else $error("ready without access");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule

bind cpsq_core cpsq_core_chk #(.STACK_DEPTH(STACK_DEPTH), .SP_W(SP_W)) cpsq_core_chk_inst (
	.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.prog_addr(prog_addr), .prog_data(prog_data), .int_req(int_req), .int_ack(int_ack),
	.instruction_phase_clocks(instruction_phase_clocks));

// ===== test/cpsq_core_tb.sv
// cpsq_core_tb: self-checking bench for the sequencer core
module cpsq_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic int_req = 1'b0;
	wire pready;
	wire [31:0] prdata;
	wire pslverr;
	wire [10:0] prog_addr;
	wire [15:0] prog_data;
	wire int_ack;
	wire [3:0] phase;
	logic [31:0] rd;
	logic er;
	int n_mismatch = 0;
	int check_count = 0;

	cpsq_core cpsq_core_inst (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .prog_addr(prog_addr),
		.prog_data(prog_data), .int_req(int_req), .int_ack(int_ack),
		.instruction_phase_clocks(phase));
	cpsq_prog_mem cpsq_prog_mem_inst (.core_clk(core_clk), .prog_addr(prog_addr),
		.prog_data(prog_data));

	initial begin
		forever #20 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_addr(input logic [10:0] a);
		int n;
		n = 0;
		while (prog_addr !== a && n < 300) begin
			@(posedge core_clk);
			n++;
		end
		chk({21'h0, prog_addr}, {21'h0, a});
	endtask

	task automatic tally_and_finish();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		chk({28'h0, phase}, 32'h1);
		chk({21'h0, prog_addr}, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, 12'h004, 32'hFF);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 12'h008, 32'h35);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h35);
	endtask

	task automatic t_call();
		logic [10:0] exp_tr [6] = '{11'h000, 11'h001, 11'h010, 11'h011, 11'h001, 11'h002};
		logic [10:0] q [$];
		apb(1'b1, 12'h010, 32'h1);
		repeat (30) begin
			@(negedge core_clk);
			if (phase === 4'h1) q.push_back(prog_addr);
		end
		for (int i = 0; i < 6; i++) begin
			// call, push, return and advance
			chk({21'h0, q[i]}, {21'h0, exp_tr[i]});
		end
		wait_addr(11'h101);
	endtask

	task automatic t_pcl_alu();
		apb(1'b1, 12'h000, 32'h20);
		wait_addr(11'h120);
		wait_addr(11'h122);
		repeat (8) @(posedge core_clk);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rd, 32'h7);
	endtask

	task automatic t_int();
		int n;
		n = 0;
		apb(1'b1, 12'h010, 32'h3);
		int_req <= 1'b1;
		while (int_ack !== 1'b1 && n < 100) begin
			@(posedge core_clk);
			n++;
		end
		chk({31'h0, int_ack}, 32'h1);
		int_req <= 1'b0;
		wait_addr(11'h004);
		wait_addr(11'h122);
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		t_regs();
		t_call();
		t_pcl_alu();
		t_int();
		tally_and_finish();
	end

	initial begin
		repeat (5000) @(posedge core_clk);
		n_mismatch++;
		tally_and_finish();
	end
endmodule

// ===== test/cpsq_prog_mem.sv
// cpsq_prog_mem: program memory model with a fixed test program
module cpsq_prog_mem (
	input wire core_clk,
	input wire [10:0] prog_addr,
	output logic [15:0] prog_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] rom [0:2047];

	initial begin
		prog_data = 16'h0000;
		for (int i = 0; i < 2048; i++) begin
			rom[i] = 16'h0000;
		end
		rom[11'h000] = 16'hA810;
		rom[11'h001] = 16'hA101;
		rom[11'h004] = 16'hB800;
		rom[11'h010] = 16'hB000;
		rom[11'h101] = 16'hA101;
		rom[11'h120] = 16'hC0CB;
		rom[11'h121] = 16'h0800;
		rom[11'h122] = 16'hA122;
		rom[11'h123] = 16'hA122;
	end

	// one-cycle synchronous read
	always @(posedge core_clk) begin
		prog_data <= rom[prog_addr];
	end
endmodule
